// file: verilog/flash_ctrl_pkg.sv
// Shared constants for the flash program/erase controller
package flash_ctrl_pkg;
    localparam int ARRAY_BYTES = 2048;
    localparam int ADDR_W = 11;
    localparam int SECTORS = 8;
    localparam int SECTOR_BYTES = 256;
    localparam int PAGE_BYTES = 16;
    localparam int CFG_BYTES = 16;
    // Register offsets
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_ADDRL = 2'h2;
    localparam logic [1:0] REG_ADDRH = 2'h3;
    // Control field: bits 3:0 command, bit 7 busy on read
    localparam int CMD_LSB = 0;
    localparam int BUSY_BIT = 7;
    localparam int CFGSEL_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] SECURE_NONE = 8'h00;
    // Commands
    localparam logic [3:0] CMD_LOAD_CLR = 4'h1;
    localparam logic [3:0] CMD_PROGRAM = 4'h2;
    localparam logic [3:0] CMD_ERASE_BYTE = 4'h3;
    localparam logic [3:0] CMD_ERASE_PAGE = 4'h4;
    localparam logic [3:0] CMD_ERASE_SECT = 4'h5;
    localparam logic [3:0] CMD_ERASE_CHIP = 4'h6;
    localparam logic [3:0] CMD_CRC_SECT = 4'h7;
    localparam logic [3:0] CMD_CRC_ALL = 4'h8;
    localparam logic [3:0] CMD_READ_CFG = 4'h9;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int OP_TIME_US = 4000;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    // Serial link opcodes
    localparam logic [7:0] SER_WRITE_REG = 8'hA0;
    localparam logic [7:0] SER_READ_REG = 8'hB0;
endpackage

// file: verilog/flash_program_erase_control.sv
// Flash program/erase sequencer with firmware and serial programmer ports
// Summary of operation
// - Any single byte can be erased and rewritten alone.
// - Sector erase clears 256 bytes, page erase clears 16 bytes.
// - Chip erase clears the whole user array in one command.
// - Address splits into eight sectors of sixteen 16-byte pages.
// - Page buffer loads 1 to 16 bytes, programmed in one operation.
// - Configuration bytes can be erased and reprogrammed too.
// - Each operation ends within 4 ms with timing made internally.
// - No direct readback; low byte of a 32-bit CRC over a sector or whole array.
// - Code reads of secured sectors are refused, others return data.
// - Eight security bytes each guard one sector.
// - Firmware uses control/status, data and two address registers.
// - Power-up config byte is sampled once after reset only.
// - External programmer reaches the same registers over a serial link.
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control #(
    parameter int OP_CYCLES = flash_ctrl_pkg::OP_CYCLES,
    parameter logic [31:0] CRC_POLY = flash_ctrl_pkg::CRC_POLY
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [1:0] regAddr, // Register address
    input wire logic [7:0] regWrData, // Register write data
    input wire logic regWr, // Register write strobe
    input wire logic regRd, // Register read strobe
    output logic [7:0] regRdData, // Read data, cycle after strobe
    input wire logic [10:0] codeAddr, // Code read address
    input wire logic codeRd, // Code read strobe
    output logic [7:0] codeData, // Code read data
    output logic codeRefused, // Code read hit secured sector
    output logic codeValid, // Code read answer pulse
    input wire logic serClk, // Serial programming clock, sampled
    input wire logic serDataIn, // Serial data pin input
    output logic serDataOut, // Serial data pin output
    output logic serDataOe, // Serial data pin drive enable
    input wire logic serEnable, // Programmer holds device reset
    output logic [7:0] powerUpConfig, // Power-up config byte as latched
    output logic busy // Operation in progress
);
    typedef enum logic [2:0] {IDLE, ERASE, PROG, CRC, WAIT} state_e;
    state_e state_reg;
    logic [7:0] mem [flash_ctrl_pkg::ARRAY_BYTES];
    logic [7:0] cfgMem [flash_ctrl_pkg::CFG_BYTES];
    logic [7:0] secMem [flash_ctrl_pkg::SECTORS];
    logic [7:0] pageBuf [flash_ctrl_pkg::PAGE_BYTES];
    logic [15:0] pageValid_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] data_reg;
    logic [10:0] addr_reg;
    logic [11:0] opIdx_reg;
    logic [11:0] opEnd_reg;
    logic [3:0] cmd_reg;
    logic [31:0] crc_reg;
    logic [31:0] timer_reg;
    logic [1:0] crcByte_reg;
    logic cfgSampled_reg;
    // Serial link state
    logic serClkPrev_reg;
    logic [7:0] serShift_reg;
    logic [4:0] serCount_reg;
    logic [15:0] serFrame_reg;
    logic serWr;
    logic serRd;
    logic [1:0] serAddr;
    logic [7:0] serData;
    logic [7:0] serOut_reg;
    // Merged register port: serial programmer owns it while enabled
    logic anyWr;
    logic [1:0] anyAddr;
    logic [7:0] anyData;
    logic cmdStart;
    logic [3:0] newCmd;
    logic [7:0] readMux;

    function automatic logic [31:0] crcStep(input logic [31:0] c,
                                           input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {d, 24'h000000};
        for (int i = 0; i < 8; i++) begin
            r = r[31] ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [2:0] sectorOf(input logic [10:0] a);
        return a[10:8];
    endfunction

    assign serWr = serEnable && serCount_reg == 5'h19 && serFrame_reg[15:8]
        == flash_ctrl_pkg::SER_WRITE_REG;
    assign serRd = serEnable && serCount_reg == 5'h10 && serFrame_reg[15:8]
        == flash_ctrl_pkg::SER_READ_REG;
    assign serAddr = serFrame_reg[1:0];
    assign serData = serShift_reg;
    assign anyWr = serEnable ? serWr : regWr;
    assign anyAddr = serEnable ? serAddr : regAddr;
    assign anyData = serEnable ? serData : regWrData;
    assign newCmd = anyData[flash_ctrl_pkg::CMD_LSB +: 4];
    assign cmdStart = anyWr && anyAddr == flash_ctrl_pkg::REG_CTRL
        && state_reg == IDLE;

    always_comb begin
        unique case (anyAddr)
            flash_ctrl_pkg::REG_CTRL: readMux = {busy, ctrl_reg[6:0]};
            flash_ctrl_pkg::REG_DATA: readMux = data_reg;
            flash_ctrl_pkg::REG_ADDRL: readMux = addr_reg[7:0];
            flash_ctrl_pkg::REG_ADDRH: readMux = {5'h00, addr_reg[10:8]};
        endcase
    end

    // Serial frame: opcode, address, then data byte, MSB first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serClkPrev_reg <= 1'b0;
            serShift_reg <= 8'h00;
            serCount_reg <= 5'h00;
            serFrame_reg <= 16'h0000;
        end else begin
            serClkPrev_reg <= serClk;
            if (!serEnable || serCount_reg == 5'h19) begin
                serCount_reg <= 5'h00;
            end else if (serCount_reg == 5'h10) begin
                serCount_reg <= 5'h11; // Pause: read reply loads once
            end else if (serClk && !serClkPrev_reg) begin
                if (!serCount_reg[4]) begin
                    serFrame_reg <= {serFrame_reg[14:0], serDataIn};
                end
                serShift_reg <= {serShift_reg[6:0], serDataIn};
                serCount_reg <= serCount_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serOut_reg <= 8'h00;
            serDataOut <= 1'b0;
            serDataOe <= 1'b0;
        end else begin
            if (serRd) begin
                serOut_reg <= readMux;
            end else if (serClk && !serClkPrev_reg) begin
                serOut_reg <= {serOut_reg[6:0], 1'b0};
            end
            serDataOut <= serOut_reg[7];
            serDataOe <= serEnable && serCount_reg[4] && serFrame_reg[15:8]
                == flash_ctrl_pkg::SER_READ_REG;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= (regRd && !serEnable) ? readMux : 8'h00;
        end
    end

    // Register writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= flash_ctrl_pkg::CTRL_RESET;
            data_reg <= 8'h00;
            addr_reg <= 11'h000;
        end else if (anyWr) begin
            unique case (anyAddr)
                flash_ctrl_pkg::REG_CTRL: begin
                    if (state_reg == IDLE) begin
                        ctrl_reg <= anyData;
                    end
                end
                flash_ctrl_pkg::REG_DATA: data_reg <= anyData;
                flash_ctrl_pkg::REG_ADDRL: addr_reg[7:0] <= anyData;
                flash_ctrl_pkg::REG_ADDRH: addr_reg[10:8] <= anyData[2:0];
            endcase
        end else if (state_reg == CRC && opIdx_reg == opEnd_reg
                     && crcByte_reg == 2'h3) begin
            data_reg <= crc_reg[7:0];
        end
    end

    // Page buffer: data writes load at the page offset of the address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pageValid_reg <= 16'h0000;
        end else if (cmdStart && newCmd == flash_ctrl_pkg::CMD_LOAD_CLR) begin
            pageValid_reg <= 16'h0000;
        end else if (state_reg == PROG && opIdx_reg == opEnd_reg) begin
            pageValid_reg <= 16'h0000;
        end else if (anyWr && anyAddr == flash_ctrl_pkg::REG_DATA
                     && state_reg == IDLE) begin
            pageValid_reg[addr_reg[3:0]] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (anyWr && anyAddr == flash_ctrl_pkg::REG_DATA
            && state_reg == IDLE) begin
            pageBuf[addr_reg[3:0]] <= anyData;
        end
    end

    // Sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= IDLE;
            cmd_reg <= 4'h0;
            opIdx_reg <= 12'h000;
            opEnd_reg <= 12'h000;
            timer_reg <= 32'h00000000;
            crc_reg <= flash_ctrl_pkg::CRC_INIT;
            crcByte_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    timer_reg <= 32'h00000000;
                    crcByte_reg <= 2'h0;
                    if (cmdStart) begin
                        cmd_reg <= newCmd;
                        crc_reg <= flash_ctrl_pkg::CRC_INIT;
                        unique case (newCmd)
                            flash_ctrl_pkg::CMD_ERASE_BYTE: begin
                                opIdx_reg <= {1'b0, addr_reg};
                                opEnd_reg <= {1'b0, addr_reg};
                                state_reg <= ERASE;
                            end
                            flash_ctrl_pkg::CMD_ERASE_PAGE: begin
                                opIdx_reg <= {1'b0, addr_reg[10:4], 4'h0};
                                opEnd_reg <= {1'b0, addr_reg[10:4], 4'hF};
                                state_reg <= ERASE;
                            end
                            flash_ctrl_pkg::CMD_ERASE_SECT: begin
                                opIdx_reg <= {1'b0, sectorOf(addr_reg), 8'h00};
                                opEnd_reg <= {1'b0, sectorOf(addr_reg), 8'hFF};
                                state_reg <= ERASE;
                            end
                            flash_ctrl_pkg::CMD_ERASE_CHIP: begin
                                opIdx_reg <= 12'h000;
                                opEnd_reg <= 12'h7FF;
                                state_reg <= ERASE;
                            end
                            flash_ctrl_pkg::CMD_PROGRAM: begin
                                opIdx_reg <= {1'b0, addr_reg[10:4], 4'h0};
                                opEnd_reg <= {1'b0, addr_reg[10:4], 4'hF};
                                state_reg <= PROG;
                            end
                            flash_ctrl_pkg::CMD_CRC_SECT: begin
                                opIdx_reg <= {1'b0, sectorOf(addr_reg), 8'h00};
                                opEnd_reg <= {1'b0, sectorOf(addr_reg), 8'hFF};
                                state_reg <= CRC;
                            end
                            flash_ctrl_pkg::CMD_CRC_ALL: begin
                                opIdx_reg <= 12'h000;
                                opEnd_reg <= 12'h7FF;
                                state_reg <= CRC;
                            end
                            default: state_reg <= IDLE;
                        endcase
                    end
                end
                ERASE, PROG: begin
                    timer_reg <= timer_reg + 32'h00000001;
                    if (opIdx_reg == opEnd_reg) begin
                        state_reg <= WAIT;
                    end else begin
                        opIdx_reg <= opIdx_reg + 12'h001;
                    end
                end
                CRC: begin
                    timer_reg <= timer_reg + 32'h00000001;
                    crc_reg <= crcStep(crc_reg, mem[opIdx_reg[10:0]]);
                    if (opIdx_reg == opEnd_reg) begin
                        crcByte_reg <= 2'h3;
                        state_reg <= (crcByte_reg == 2'h3) ? WAIT : CRC;
                    end else begin
                        opIdx_reg <= opIdx_reg + 12'h001;
                    end
                end
                WAIT: begin
                    // Fixed pulse time keeps every operation at the 4 ms bound
                    timer_reg <= timer_reg + 32'h00000001;
                    if (timer_reg >= 32'(OP_CYCLES - 1)) begin
                        state_reg <= IDLE;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // Array writes; config select bit routes to configuration/security bytes
    always_ff @(posedge sys_clk) begin
        if (ctrl_reg[flash_ctrl_pkg::CFGSEL_BIT]) begin
            if (state_reg == ERASE && opIdx_reg[10:4] == 7'h00) begin
                cfgMem[opIdx_reg[3:0]] <= flash_ctrl_pkg::ERASED_BYTE;
            end else if (state_reg == ERASE && opIdx_reg[10:3] == 8'h02) begin
                secMem[opIdx_reg[2:0]] <= flash_ctrl_pkg::SECURE_NONE;
            end else if (state_reg == PROG && pageValid_reg[opIdx_reg[3:0]]) begin
                if (opIdx_reg[10:4] == 7'h00) begin
                    cfgMem[opIdx_reg[3:0]] <= pageBuf[opIdx_reg[3:0]];
                end else if (opIdx_reg[10:3] == 8'h02) begin
                    secMem[opIdx_reg[2:0]] <= pageBuf[opIdx_reg[3:0]];
                end
            end
        end else if (state_reg == ERASE) begin
            mem[opIdx_reg[10:0]] <= flash_ctrl_pkg::ERASED_BYTE;
        end else if (state_reg == PROG && pageValid_reg[opIdx_reg[3:0]]) begin
            mem[opIdx_reg[10:0]] <= pageBuf[opIdx_reg[3:0]];
        end
    end

    // Busy follows the next state, so the pin leaves a flop directly
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (state_reg == IDLE) begin
            busy <= cmdStart && newCmd inside {[flash_ctrl_pkg::CMD_PROGRAM:
                flash_ctrl_pkg::CMD_CRC_ALL]};
        end else begin
            busy <= !(state_reg == WAIT
                && timer_reg >= 32'(OP_CYCLES - 1));
        end
    end

    // Power-up configuration caught once after reset release
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgSampled_reg <= 1'b0;
            powerUpConfig <= 8'h00;
        end else if (!cfgSampled_reg) begin
            cfgSampled_reg <= 1'b1;
            powerUpConfig <= cfgMem[0];
        end
    end

    // Code reads from the processor
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            codeData <= 8'h00;
            codeRefused <= 1'b0;
            codeValid <= 1'b0;
        end else begin
            codeValid <= codeRd;
            codeRefused <= codeRd && secMem[sectorOf(codeAddr)] != 8'h00;
            if (codeRd && secMem[sectorOf(codeAddr)] == 8'h00) begin
                codeData <= mem[codeAddr];
            end else begin
                codeData <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/flash_program_erase_control_checker.sv
// Port-level assertions for the flash program/erase controller
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_checker #(
    parameter int OP_CYCLES = 64
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Async reset
    input wire logic [1:0] regAddr, // Register address
    input wire logic [7:0] regWrData, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic [7:0] regRdData, // Read data
    input wire logic codeRd, // Code read strobe
    input wire logic [7:0] codeData, // Code read data
    input wire logic codeRefused, // Refusal flag
    input wire logic codeValid, // Code answer
    input wire logic serEnable, // Programmer owns port
    input wire logic serDataOe, // Serial data drive
    input wire logic [7:0] powerUpConfig, // Latched config
    input wire logic busy // Operation running
);
    // A full-array CRC takes one step per byte, counted inside the timed wait, which it can outlast
    localparam int BUSY_MAX = OP_CYCLES + 4200;
    int busyCnt;
    logic [1:0] settle;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busyCnt <= 0;
        end else begin
            busyCnt <= busy ? busyCnt + 1 : 0;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rd_data_quiet: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside answer cycle");
    a_busy_in_status: assert property ($past(regRd)
        && $past(regAddr) == flash_ctrl_pkg::REG_CTRL
        |-> regRdData[7] == $past(busy)) else $error("status busy bit wrong");
    a_busy_starts: assert property (regWr && !busy && !serEnable
        && regAddr == flash_ctrl_pkg::REG_CTRL && regWrData[3:0] inside
        {[4'h2:4'h8]} |=> busy) else $error("command did not start");
    a_busy_cause: assert property ($rose(busy)
        |-> $past(regWr) || $past(serEnable)) else $error("busy unprompted");
    a_op_bounded: assert property (busyCnt <= BUSY_MAX)
        else $error("operation too long");
    a_code_answer: assert property (codeRd |=> codeValid)
        else $error("code read unanswered");
    a_code_pulse: assert property (codeValid |-> $past(codeRd))
        else $error("code answer without read");
    a_refused_blank: assert property (codeRefused
        |-> codeValid && codeData == 8'h00) else $error("refused read leaks");
    a_cfg_frozen: assert property (settle == 2'h3
        |-> powerUpConfig === $past(powerUpConfig))
        else $error("config changed after start");
    a_ser_quiet: assert property (!serEnable && !$past(serEnable)
        |-> !serDataOe) else $error("serial drive while not owned");
endmodule
bind flash_program_erase_control flash_program_erase_control_checker #(
    .OP_CYCLES(OP_CYCLES)) chk_u (.sys_clk(sys_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .codeRd(codeRd), .codeData(codeData),
    .codeRefused(codeRefused), .codeValid(codeValid),
    .serEnable(serEnable), .serDataOe(serDataOe),
    .powerUpConfig(powerUpConfig), .busy(busy));
`default_nettype wire

// file: bench/serial_programmer_model.sv
// External serial programmer driving clock, data and reset ownership
`timescale 1ns/1ps
`default_nettype none
module serial_programmer_model (
    input wire logic sys_clk, // Bench clock for pacing
    output logic serClk, // Serial clock, still outside frames
    output logic serData, // Serial data driven by programmer
    output logic serEnable // Programmer holds device reset
);
    initial begin
        serClk = 1'b0;
        serData = 1'b1;
        serEnable = 1'b0;
    end
    task automatic own(input logic on);
        @(posedge sys_clk);
        serEnable <= on;
        repeat (4) @(posedge sys_clk);
    endtask
    // Slow bits: eight system clocks each, so sampling never misses an edge
    task automatic sendByte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge sys_clk);
            serData <= b[i];
            repeat (3) @(posedge sys_clk);
            serClk <= 1'b1;
            repeat (4) @(posedge sys_clk);
            serClk <= 1'b0;
        end
    endtask
    task automatic sendWrite(input logic [1:0] a, input logic [7:0] d);
        sendByte(flash_ctrl_pkg::SER_WRITE_REG);
        sendByte({6'h00, a});
        sendByte(d);
        @(posedge sys_clk);
        serData <= ~serData;
    endtask
endmodule
`default_nettype wire

// file: bench/flash_program_erase_control_tb.sv
// Self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
    error_cnt++; $display("CHECK FAILED t=%0t got %0h exp %0h", \
    $time, got, exp); end end
module flash_program_erase_control_tb;
    logic sys_clk = 1'b0;
    logic rst, regWr, regRd, codeRd, codeRefused, codeValid, rdPend;
    logic serClk, serDataOut, serDataOe, serEnable, progData, busy;
    logic [1:0] regAddr;
    logic [7:0] regWrData, regRdData, codeData, powerUpConfig, d;
    logic [10:0] codeAddr;
    logic [15:0] rdQ[$];
    logic [8:0] codeQ[$];
    logic [7:0] img[2048];
    logic [31:0] crc;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h40ff;
    wire logic serDataIn = serDataOe ? serDataOut : progData;
    always #4 sys_clk = ~sys_clk;
    flash_program_erase_control #(.OP_CYCLES(64)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .codeAddr(codeAddr), .codeRd(codeRd),
        .codeData(codeData), .codeRefused(codeRefused),
        .codeValid(codeValid), .serClk(serClk), .serDataIn(serDataIn),
        .serDataOut(serDataOut), .serDataOe(serDataOe),
        .serEnable(serEnable), .powerUpConfig(powerUpConfig), .busy(busy));
    serial_programmer_model prog_u (.sys_clk(sys_clk), .serClk(serClk),
        .serData(progData), .serEnable(serEnable));
    task automatic summarize;
        if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= v;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] e, m);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        rdQ.push_back({m, e & m});
        @(posedge sys_clk);
        regRd <= 1'b0;
    endtask
    task automatic waitIdle;
        int n = 0;
        repeat (2) @(posedge sys_clk);
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 20000) error_cnt++;
    endtask
    task automatic cmd(input logic [3:0] c, input logic cf, logic [10:0] a);
        wr(flash_ctrl_pkg::REG_ADDRL, a[7:0]);
        wr(flash_ctrl_pkg::REG_ADDRH, {5'h00, a[10:8]});
        wr(flash_ctrl_pkg::REG_CTRL, {1'b0, cf, 2'b00, c});
        waitIdle();
    endtask
    task automatic load(input logic [10:0] a, input logic [7:0] v);
        wr(flash_ctrl_pkg::REG_ADDRL, a[7:0]);
        wr(flash_ctrl_pkg::REG_DATA, v);
    endtask
    task automatic erase(input logic [3:0] c, input logic [10:0] a, lo,
                         input int n);
        cmd(c, 1'b0, a);
        for (int i = 0; i < n; i++) img[lo + i] = 8'hFF;
    endtask
    task automatic crd(input logic [10:0] a, input logic r);
        @(posedge sys_clk);
        codeAddr <= a;
        codeRd <= 1'b1;
        codeQ.push_back({r, r ? 8'h00 : img[a]});
        @(posedge sys_clk);
        codeRd <= 1'b0;
    endtask
    function automatic logic [31:0] crcOf(input int base, input int n);
        logic [31:0] c = flash_ctrl_pkg::CRC_INIT;
        for (int i = 0; i < n; i++) begin
            c = c ^ {img[base + i], 24'h000000};
            for (int b = 0; b < 8; b++)
                c = c[31] ? (c << 1) ^ flash_ctrl_pkg::CRC_POLY : c << 1;
        end
        return c;
    endfunction
    // Answers are compared in the cycle they stand, oldest note first
    always @(posedge sys_clk) begin
        if (rdPend) begin
            `CHK(regRdData & rdQ[0][15:8], rdQ[0][7:0])
            void'(rdQ.pop_front());
        end
        rdPend <= regRd;
        if (codeValid === 1'b1) begin
            `CHK({codeRefused, codeData}, codeQ[0])
            void'(codeQ.pop_front());
        end
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        error_cnt++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        {regWr, regRd, codeRd, regAddr, regWrData, codeAddr} = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(flash_ctrl_pkg::REG_CTRL, flash_ctrl_pkg::CTRL_RESET, 8'hFF);
        erase(flash_ctrl_pkg::CMD_ERASE_CHIP, 11'h000, 11'h000, 2048);
        cmd(flash_ctrl_pkg::CMD_ERASE_PAGE, 1'b1, 11'h010);
        crd(11'h005, 1'b0);
        cmd(flash_ctrl_pkg::CMD_LOAD_CLR, 1'b1, 11'h010);
        for (int i = 0; i < 8; i++) load(11'h010 + i, i == 7 ? 8'h5A : 8'h00);
        cmd(flash_ctrl_pkg::CMD_PROGRAM, 1'b1, 11'h010);
        crd(11'h010, 1'b0);
        crd(11'h7F0, 1'b1);
        cmd(flash_ctrl_pkg::CMD_LOAD_CLR, 1'b0, 11'h310);
        for (int i = 0; i < 16; i++) begin
            d = 8'($random(seed));
            load(11'h310 + i, d);
            img[11'h310 + i] = d;
        end
        wr(flash_ctrl_pkg::REG_CTRL, {4'h0, flash_ctrl_pkg::CMD_PROGRAM});
        rd(flash_ctrl_pkg::REG_CTRL, 8'h80, 8'h80);
        wr(flash_ctrl_pkg::REG_CTRL, {4'h0, flash_ctrl_pkg::CMD_ERASE_CHIP});
        waitIdle();
        for (int i = 0; i < 16; i++) crd(11'h310 + i, 1'b0);
        cmd(flash_ctrl_pkg::CMD_LOAD_CLR, 1'b0, 11'h309);
        d = 8'($random(seed));
        load(11'h309, d);
        img[11'h309] = d;
        cmd(flash_ctrl_pkg::CMD_PROGRAM, 1'b0, 11'h309);
        crd(11'h308, 1'b0);
        crd(11'h309, 1'b0);
        erase(flash_ctrl_pkg::CMD_ERASE_BYTE, 11'h315, 11'h315, 1);
        for (int i = 4; i < 7; i++) crd(11'h310 + i, 1'b0);
        cmd(flash_ctrl_pkg::CMD_CRC_SECT, 1'b0, 11'h300);
        crc = crcOf(11'h300, 256);
        rd(flash_ctrl_pkg::REG_DATA, crc[7:0], 8'hFF);
        erase(flash_ctrl_pkg::CMD_ERASE_PAGE, 11'h31A, 11'h310, 16);
        crd(11'h31F, 1'b0);
        crd(11'h309, 1'b0);
        prog_u.own(1'b1);
        wr(flash_ctrl_pkg::REG_CTRL, {4'h0, flash_ctrl_pkg::CMD_ERASE_CHIP});
        repeat (2) @(posedge sys_clk);
        `CHK(busy, 1'b0)
        prog_u.sendWrite(flash_ctrl_pkg::REG_ADDRL, 8'h12);
        prog_u.sendWrite(flash_ctrl_pkg::REG_ADDRH, 8'h00);
        prog_u.sendWrite(flash_ctrl_pkg::REG_CTRL, 8'h01);
        prog_u.sendWrite(flash_ctrl_pkg::REG_DATA, 8'hA5);
        prog_u.sendWrite(flash_ctrl_pkg::REG_CTRL, 8'h02);
        waitIdle();
        prog_u.own(1'b0);
        img[11'h012] = 8'hA5;
        erase(flash_ctrl_pkg::CMD_ERASE_SECT, 11'h3A0, 11'h300, 256);
        crd(11'h309, 1'b0);
        crd(11'h012, 1'b0);
        cmd(flash_ctrl_pkg::CMD_CRC_ALL, 1'b0, 11'h000);
        crc = crcOf(0, 2048);
        rd(flash_ctrl_pkg::REG_DATA, crc[7:0], 8'hFF);
        cmd(flash_ctrl_pkg::CMD_ERASE_PAGE, 1'b1, 11'h000);
        cmd(flash_ctrl_pkg::CMD_LOAD_CLR, 1'b1, 11'h000);
        load(11'h000, 8'h3C);
        cmd(flash_ctrl_pkg::CMD_PROGRAM, 1'b1, 11'h000);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(powerUpConfig, 8'h3C)
        crd(11'h7F0, 1'b1);
        repeat (4) @(posedge sys_clk);
        summarize();
    end
endmodule
`default_nettype wire
